// [rtl/cfg_words_pkg.sv]
// package: constants of the sensor configuration words
package cfg_words_pkg;
    localparam int          WORD_COUNT          = 16;
    // word indices; byte address is four times the index
    localparam logic [3:0]  IDX_ZERO_OFFSET     = 4'h2;
    localparam logic [3:0]  IDX_SPAN            = 4'h3;
    localparam logic [3:0]  IDX_MODE3_THRESHOLD = 4'h4;
    localparam logic [3:0]  IDX_THERMAL_LIMITS  = 4'h6;
    localparam logic [3:0]  IDX_CONTROL_ONE     = 4'h7;
    localparam logic [3:0]  IDX_DIAG_CONTROL    = 4'h8;
    localparam logic [3:0]  IDX_CLAMP_LEVELS    = 4'h9;
    localparam logic [3:0]  IDX_CHECKSUM        = 4'hf;
    // extra registers beyond the stored words
    localparam logic [11:0] ADDR_WORDS_END      = 12'h040;
    localparam logic [11:0] ADDR_CONTROL        = 12'h040;
    localparam logic [11:0] ADDR_STATUS         = 12'h044;
    localparam logic [11:0] ADDR_DECODE_A       = 12'h048;
    localparam logic [11:0] ADDR_DECODE_B       = 12'h04c;
    // control register bits
    localparam int          CTL_LOAD            = 0;
    localparam int          CTL_PROGRAM         = 1;
    localparam int          CTL_CRC_OK          = 2;
    // control_word_one fields
    localparam int          C1_PROG_LOCK        = 13;
    localparam int          C1_EDGE_RATE        = 11;
    localparam int          C1_OUT_LVL_HI       = 10;
    localparam int          C1_OUT_LVL_LO       = 9;
    localparam int          C1_IN_LVL_HI        = 8;
    localparam int          C1_IN_LVL_LO        = 7;
    localparam int          C1_OSEL_HI          = 6;
    localparam int          C1_OSEL_LO          = 4;
    localparam logic [15:0] C1_FIXED_MASK       = 16'hd00f;
    localparam logic [15:0] C1_FIXED_VALUE      = 16'h4006;
    // diag_control_word fields
    localparam int          C2_IN_LVL_MSB       = 11;
    localparam int          C2_AUTO_RETURN      = 9;
    localparam int          C2_THERM_EN         = 8;
    localparam int          C2_THERM_CNT_HI     = 7;
    localparam int          C2_THERM_CNT_LO     = 6;
    localparam int          C2_OUT_DIAG_EN      = 5;
    localparam int          C2_OUT_CNT_HI       = 4;
    localparam int          C2_OUT_CNT_LO       = 3;
    localparam int          C2_IN_DIAG_EN       = 2;
    localparam int          C2_IN_CNT_HI        = 1;
    localparam int          C2_IN_CNT_LO        = 0;
    localparam logic [15:0] C2_FIXED_MASK       = 16'hf400;
    localparam logic [15:0] C2_FIXED_VALUE      = 16'h0400;
    // reset values of the words
    localparam logic [15:0] RST_ZERO_OFFSET     = 16'h0000;
    localparam logic [15:0] RST_SPAN            = 16'h0000;
    localparam logic [15:0] RST_THERMAL_LIMITS  = 16'hfaf8;
    localparam logic [15:0] RST_CONTROL_ONE     = 16'h4046;
    localparam logic [15:0] RST_DIAG_CONTROL    = 16'h0704;
    localparam logic [15:0] RST_CLAMP_LEVELS    = 16'h00ff;
    localparam logic [15:0] RST_OTHER           = 16'h0000;
    // scale factors in fixed point
    localparam logic [7:0]  TEMP_BASE_NEG       = 8'h32;    // limit = code - 50 degC
    localparam logic [9:0]  LOW_CLAMP_BASE      = 10'h032;  // 5.0 % in 0.1 % units
    localparam logic [9:0]  HIGH_CLAMP_BASE     = 10'h2b7;  // 69.5 % in 0.1 % units
    localparam logic [7:0]  EDGE_NS_FAST        = 8'h96;    // 150 ns
    localparam logic [9:0]  EDGE_NS_SLOW        = 10'h2ee;  // 750 ns
    typedef enum logic [2:0] {
        OSEL_DIGITAL   = 3'b000,
        OSEL_DIGITAL_N = 3'b001,
        OSEL_ANALOG_M1 = 3'b100,
        OSEL_ANALOG_M2 = 3'b101,
        OSEL_ANALOG_M3 = 3'b110,
        OSEL_ANALOG    = 3'b111
    } osel_t;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOAD = 2'b01,
        PH_PROG = 2'b10
    } phase_t;
endpackage

// [rtl/angle_sensor_config_words.sv]
// angle sensor configuration words: working ram, nv shadow, field decode, ahb-lite slave
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// - angle words are unsigned 0.00275 degree steps
// - thermal word: shutdown high byte, warning low
// - control word one field layout, fixed bits
// - prog_lock blocks programming when checksum valid
// - data_edge_rate picks 150 or 750 ns
// - output_check_level picks 10/5/2/1 percent
// - input_check_level three bits, five levels
// - output_select codes digital, complement, analog modes
// - diag control word field layout, fixed bits
// - auto_return_normal gated by valid checksum
// - thermal_watch_enable switches temperature supervision
// - thermal_fault_count decodes 0/2/4/8
// - output_diag_enable switches output diagnosis
// - output_fault_tally 01 is 2, 10 is 4
// - input_diag_enable switches input diagnosis
// - input_fault_tally decodes 0/2/4/8
// - clamp levels 5 and 69.5 percent plus 0.1
// - power-on copies sixteen nv words into ram
// - locked at power-on with checksum valid ignores program command
module angle_sensor_config_words
    import cfg_words_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic              input_check_fail,
    input  wire logic              output_check_fail,
    input  wire logic              thermal_check_fail,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   data_edge_slow,
    output logic [2:0]             output_select,
    output logic [1:0]             output_check_level,
    output logic [2:0]             input_check_level,
    output logic                   auto_return_normal,
    output logic                   thermal_watch_enable,
    output logic                   output_diag_enable,
    output logic                   input_diag_enable,
    output logic                   input_fault,
    output logic                   output_fault,
    output logic                   thermal_fault
);

    typedef struct packed {
        logic [WORD_COUNT-1:0][15:0] ram;
        logic [WORD_COUNT-1:0][15:0] nv;
        phase_t                      phase;
        logic [3:0]                  idx;
        logic                        lock_at_power_on;
        logic                        crc_ok;
        logic                        prog_refused;
        logic                        wr_pend;
        logic [3:0]                  wr_idx;
        logic [ADDR_W-1:0]           wr_addr;
        logic [3:0]                  in_cnt;
        logic [3:0]                  out_cnt;
        logic [3:0]                  th_cnt;
        logic [31:0]                 hrdata;
        logic                        data_edge_slow;
        logic [2:0]                  output_select;
        logic [1:0]                  output_check_level;
        logic [2:0]                  input_check_level;
        logic                        auto_return_normal;
        logic                        thermal_watch_enable;
        logic                        output_diag_enable;
        logic                        input_diag_enable;
        logic                        input_fault;
        logic                        output_fault;
        logic                        thermal_fault;
    } state_t;

    state_t st;
    state_t next_st;

    // error counter code to tolerated consecutive failures
    function automatic logic [3:0] tally_limit(input logic [1:0] code);
        unique case (code)
            2'b00:   tally_limit = 4'h0;
            2'b01:   tally_limit = 4'h2;
            2'b10:   tally_limit = 4'h4;
            2'b11:   tally_limit = 4'h8;
        endcase
    endfunction

    // counts a run of failures; a pass restarts it
    function automatic logic [3:0] tally_step(input logic en, input logic fail, input logic [3:0] cnt,
                                              input logic [3:0] lim);
        if (!en || !fail) begin
            tally_step = 4'h0;
        end else if (cnt <= lim) begin
            tally_step = cnt + 4'h1;
        end else begin
            tally_step = cnt;
        end
    endfunction

    // forces the fixed bits of the two control words
    function automatic logic [15:0] fix_word(input logic [3:0] idx, input logic [15:0] w);
        if (idx == IDX_CONTROL_ONE) begin
            fix_word = (w & ~C1_FIXED_MASK) | C1_FIXED_VALUE;
        end else if (idx == IDX_DIAG_CONTROL) begin
            fix_word = (w & ~C2_FIXED_MASK) | C2_FIXED_VALUE;
        end else begin
            fix_word = w;
        end
    endfunction

    function automatic logic [15:0] nv_default(input logic [3:0] idx);
        unique case (idx)
            IDX_ZERO_OFFSET:    nv_default = RST_ZERO_OFFSET;
            IDX_SPAN:           nv_default = RST_SPAN;
            IDX_THERMAL_LIMITS: nv_default = RST_THERMAL_LIMITS;
            IDX_CONTROL_ONE:    nv_default = RST_CONTROL_ONE;
            IDX_DIAG_CONTROL:   nv_default = RST_DIAG_CONTROL;
            IDX_CLAMP_LEVELS:   nv_default = RST_CLAMP_LEVELS;
            default:            nv_default = RST_OTHER;
        endcase
    endfunction

    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] thl;
    logic [15:0] clw;
    logic [7:0]  shutdown_limit_code;
    logic [7:0]  warning_limit_code;
    logic [7:0]  low_clamp_code;
    logic [7:0]  high_clamp_code;
    logic [7:0]  shutdown_degc;
    logic [7:0]  warning_degc;
    logic [9:0]  low_clamp_permille;
    logic [9:0]  high_clamp_permille;
    logic [9:0]  edge_ns;
    logic        addr_ok;
    logic        is_word;
    logic [3:0]  rd_idx;

    assign c1  = st.ram[IDX_CONTROL_ONE];
    assign c2  = st.ram[IDX_DIAG_CONTROL];
    assign thl = st.ram[IDX_THERMAL_LIMITS];
    assign clw = st.ram[IDX_CLAMP_LEVELS];
    assign shutdown_limit_code = thl[15:8];
    assign warning_limit_code  = thl[7:0];
    assign shutdown_degc = shutdown_limit_code - TEMP_BASE_NEG;   // signed degC
    assign warning_degc  = warning_limit_code - TEMP_BASE_NEG;
    assign low_clamp_code  = clw[15:8];
    assign high_clamp_code = clw[7:0];
    assign low_clamp_permille  = LOW_CLAMP_BASE + {2'b00, low_clamp_code};
    assign high_clamp_permille = HIGH_CLAMP_BASE + {2'b00, high_clamp_code};
    assign edge_ns = c1[C1_EDGE_RATE] ? EDGE_NS_SLOW : {2'b00, EDGE_NS_FAST};
    assign addr_ok = (haddr[1:0] == 2'b00);
    assign is_word = (haddr < ADDR_W'(ADDR_WORDS_END));
    assign rd_idx  = haddr[5:2];

    always_comb begin
        logic take;
        logic [3:0] lim_in;
        logic [3:0] lim_out;
        logic [3:0] lim_th;
        next_st = st;
        take    = hsel && hready && htrans[1] && addr_ok;
        lim_in  = tally_limit(c2[C2_IN_CNT_HI:C2_IN_CNT_LO]);
        lim_out = tally_limit(c2[C2_OUT_CNT_HI:C2_OUT_CNT_LO]);
        lim_th  = tally_limit(c2[C2_THERM_CNT_HI:C2_THERM_CNT_LO]);

        // data phase of a write
        next_st.wr_pend = 1'b0;
        if (st.wr_pend) begin
            if (st.wr_addr < ADDR_W'(ADDR_WORDS_END)) begin
                next_st.ram[st.wr_idx] = fix_word(st.wr_idx, hwdata[15:0]);
            end else if (st.wr_addr == ADDR_W'(ADDR_CONTROL)) begin
                next_st.crc_ok = hwdata[CTL_CRC_OK];
                if (hwdata[CTL_LOAD] && st.phase == PH_IDLE) begin
                    next_st.phase = PH_LOAD;
                    next_st.idx   = 4'h0;
                end else if (hwdata[CTL_PROGRAM] && st.phase == PH_IDLE) begin
                    if (st.lock_at_power_on && st.crc_ok) begin
                        next_st.prog_refused = 1'b1;
                    end else begin
                        next_st.prog_refused = 1'b0;
                        next_st.phase = PH_PROG;
                        next_st.idx   = 4'h0;
                    end
                end
            end
        end
        if (take && hwrite) begin
            next_st.wr_pend = 1'b1;
            next_st.wr_idx  = rd_idx;
            next_st.wr_addr = haddr;
        end

        // reads are answered from registered data in the data phase
        if (take && !hwrite) begin
            if (is_word) begin
                next_st.hrdata = {16'h0000, st.ram[rd_idx]};   // unsigned words
            end else if (haddr == ADDR_W'(ADDR_CONTROL)) begin
                next_st.hrdata = {29'h0, st.crc_ok, 2'b00};
            end else if (haddr == ADDR_W'(ADDR_STATUS)) begin
                next_st.hrdata = {24'h0, st.thermal_fault, st.output_fault, st.input_fault,
                                  st.prog_refused, st.lock_at_power_on, 1'b0, st.phase};
            end else if (haddr == ADDR_W'(ADDR_DECODE_A)) begin
                next_st.hrdata = {6'h00, edge_ns, shutdown_degc, warning_degc};
            end else if (haddr == ADDR_W'(ADDR_DECODE_B)) begin
                next_st.hrdata = {6'h00, low_clamp_permille, 6'h00, high_clamp_permille};
            end else begin
                next_st.hrdata = 32'h0;
            end
        end

        // power-on copy and programming walk the sixteen words
        unique case (st.phase)
            PH_IDLE: begin
            end
            PH_LOAD: begin
                next_st.ram[st.idx] = st.nv[st.idx];
                if (st.idx == IDX_CONTROL_ONE) begin
                    next_st.lock_at_power_on = st.nv[st.idx][C1_PROG_LOCK];
                end
                next_st.idx = st.idx + 4'h1;
                if (st.idx == IDX_CHECKSUM) begin
                    next_st.phase = PH_IDLE;
                end
            end
            PH_PROG: begin
                next_st.nv[st.idx] = st.ram[st.idx];
                next_st.idx = st.idx + 4'h1;
                if (st.idx == IDX_CHECKSUM) begin
                    next_st.phase = PH_IDLE;
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase

        // decoded fields
        next_st.data_edge_slow       = c1[C1_EDGE_RATE];
        next_st.output_select        = c1[C1_OSEL_HI:C1_OSEL_LO];
        next_st.output_check_level   = c1[C1_OUT_LVL_HI:C1_OUT_LVL_LO];
        next_st.input_check_level    = {c2[C2_IN_LVL_MSB], c1[C1_IN_LVL_HI:C1_IN_LVL_LO]};
        next_st.auto_return_normal   = st.crc_ok ? c2[C2_AUTO_RETURN] : 1'b1;
        next_st.thermal_watch_enable = c2[C2_THERM_EN];
        next_st.output_diag_enable   = c2[C2_OUT_DIAG_EN];
        next_st.input_diag_enable    = c2[C2_IN_DIAG_EN];

        next_st.in_cnt  = tally_step(c2[C2_IN_DIAG_EN], input_check_fail, st.in_cnt, lim_in);
        next_st.out_cnt = tally_step(c2[C2_OUT_DIAG_EN], output_check_fail, st.out_cnt, lim_out);
        next_st.th_cnt  = tally_step(c2[C2_THERM_EN], thermal_check_fail, st.th_cnt, lim_th);
        next_st.input_fault   = (next_st.in_cnt > lim_in);
        next_st.output_fault  = (next_st.out_cnt > lim_out);
        next_st.thermal_fault = (next_st.th_cnt > lim_th);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            for (int i = 0; i < WORD_COUNT; i++) begin
                st.nv[i] <= nv_default(4'(i));
                st.ram[i] <= nv_default(4'(i));
            end
            st.phase              <= PH_LOAD;
            st.auto_return_normal <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata               = st.hrdata;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign data_edge_slow       = st.data_edge_slow;
    assign output_select        = st.output_select;
    assign output_check_level   = st.output_check_level;
    assign input_check_level    = st.input_check_level;
    assign auto_return_normal   = st.auto_return_normal;
    assign thermal_watch_enable = st.thermal_watch_enable;
    assign output_diag_enable   = st.output_diag_enable;
    assign input_diag_enable    = st.input_diag_enable;
    assign input_fault          = st.input_fault;
    assign output_fault         = st.output_fault;
    assign thermal_fault        = st.thermal_fault;

endmodule // angle_sensor_config_words

// [sim/cfg_words_checker_asserts.sv]
// checker: port-level properties of the configuration word block
`timescale 1ns/1ns
module cfg_words_checker
    import cfg_words_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              input_check_fail,
    input wire logic              data_edge_slow,
    input wire logic [2:0]        output_select,
    input wire logic [1:0]        output_check_level,
    input wire logic [2:0]        input_check_level,
    input wire logic              thermal_watch_enable,
    input wire logic              output_diag_enable,
    input wire logic              input_diag_enable,
    input wire logic              input_fault
);
    localparam logic [ADDR_W-1:0] A_C1 = ADDR_W'({IDX_CONTROL_ONE, 2'b00});
    localparam logic [ADDR_W-1:0] A_C2 = ADDR_W'({IDX_DIAG_CONTROL, 2'b00});
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    // marks the data phase of a taken write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence c1_data; wr_pend && wr_addr == A_C1; endsequence
    sequence c2_data; wr_pend && wr_addr == A_C2; endsequence
    sequence first_edge; $rose(hresetn); endsequence
    a_defaults_after_reset: assert property (first_edge |-> ##1 output_select == 3'b100 && !data_edge_slow
        && thermal_watch_enable && input_diag_enable && !output_diag_enable && output_check_level == 2'b00)
        else $error("decoded outputs not at default after reset");
    a_edge_rate_follows: assert property (c1_data |-> ##2 data_edge_slow == $past(hwdata[11], 2))
        else $error("edge rate does not follow control word one");
    a_mode_follows: assert property (c1_data |-> ##2 output_select == $past(hwdata[6:4], 2))
        else $error("output select does not follow control word one");
    a_out_level_follows: assert property (c1_data |-> ##2 output_check_level == $past(hwdata[10:9], 2)
        && input_check_level[1:0] == $past(hwdata[8:7], 2))
        else $error("check levels do not follow control word one");
    a_level_msb_follows: assert property (c2_data |-> ##2 input_check_level[2] == $past(hwdata[11], 2))
        else $error("input level msb does not follow diag word");
    a_therm_en_follows: assert property (c2_data |-> ##2 thermal_watch_enable == $past(hwdata[8], 2))
        else $error("thermal watch enable does not follow diag word");
    a_diag_en_follows: assert property (c2_data |-> ##2 output_diag_enable == $past(hwdata[5], 2)
        && input_diag_enable == $past(hwdata[2], 2))
        else $error("diagnosis enables do not follow diag word");
    a_fault_clears: assert property (!input_check_fail [*4] |-> !input_fault)
        else $error("input fault stays after passing checks");
    a_fault_cause: assert property ($rose(input_fault) |-> $past(input_check_fail) || $past(input_check_fail, 2))
        else $error("input fault rose without a failed check");
endmodule // cfg_words_checker

bind angle_sensor_config_words cfg_words_checker #(.ADDR_W(ADDR_W)) chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .input_check_fail(input_check_fail), .data_edge_slow(data_edge_slow), .output_select(output_select),
    .output_check_level(output_check_level), .input_check_level(input_check_level),
    .thermal_watch_enable(thermal_watch_enable), .output_diag_enable(output_diag_enable),
    .input_diag_enable(input_diag_enable), .input_fault(input_fault));

// [sim/sensor_check_source.sv]
// check source: drives streaks of failed diagnosis checks into the block
`timescale 1ns/1ns
module sensor_check_source (
    input  wire logic       hclk,
    input  wire logic       go,
    input  wire logic [1:0] chan,
    input  wire logic [3:0] len,
    output logic            input_check_fail,
    output logic            output_check_fail,
    output logic            thermal_check_fail
);
    logic [3:0] left = 4'h0;
    logic [1:0] sel;
    always @(posedge hclk) begin
        if (go) begin
            left <= len;
            sel  <= chan;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    // a failure stands for len cycles
    assign input_check_fail   = (left != 4'h0) && sel == 2'd0;
    assign output_check_fail  = (left != 4'h0) && sel == 2'd1;
    assign thermal_check_fail = (left != 4'h0) && sel == 2'd2;
endmodule // sensor_check_source

// [sim/test_angle_sensor_config_words.sv]
// bench: register and diagnosis tests of the configuration word block
`timescale 1ns/1ns
module test_angle_sensor_config_words;
    import cfg_words_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, go, hreadyout, hresp, i_fail, o_fail, t_fail;
    logic        input_fault, output_fault, thermal_fault, data_edge_slow, auto_return_normal;
    logic        thermal_watch_enable, output_diag_enable, input_diag_enable;
    logic [11:0] haddr;
    logic [1:0]  htrans, chan, output_check_level;
    logic [31:0] hwdata, hrdata;
    logic [3:0]  len;
    logic [2:0]  output_select, input_check_level, flt;
    int          bad_count, comparisons;
    int          lim [4] = '{0, 2, 4, 8};
    int          om [6] = '{0, 1, 4, 5, 6, 7};
    assign flt = {thermal_fault, output_fault, input_fault};
    angle_sensor_config_words #(.ADDR_W(12)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .input_check_fail(i_fail), .output_check_fail(o_fail), .thermal_check_fail(t_fail), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .data_edge_slow(data_edge_slow), .output_select(output_select),
        .output_check_level(output_check_level), .input_check_level(input_check_level),
        .auto_return_normal(auto_return_normal), .thermal_watch_enable(thermal_watch_enable),
        .output_diag_enable(output_diag_enable), .input_diag_enable(input_diag_enable),
        .input_fault(input_fault), .output_fault(output_fault), .thermal_fault(thermal_fault));
    sensor_check_source src (.hclk(hclk), .go(go), .chan(chan), .len(len), .input_check_fail(i_fail),
        .output_check_fail(o_fail), .thermal_check_fail(t_fail));
    initial hclk = 1'b0;
    always #25 hclk = ~hclk;
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdy;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            finish_test;
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // waits out a load or program walk
    task automatic settle;
        int n = 0;
        logic [31:0] q;
        repeat (2) @(posedge hclk);
        do begin
            xfer(1'b0, 12'h044, 32'h0, q);
            n++;
        end while (q[1:0] !== 2'b00 && n < 40);
        if (q[1:0] !== 2'b00) begin
            bad_count++;
            finish_test;
        end
    endtask
    task automatic cmd(input logic [31:0] d);
        wr(12'h040, d);
        settle;
    endtask
    task automatic hold;
        repeat (3) @(negedge hclk);
    endtask
    task automatic streak(input logic [1:0] c, input int n, input logic e);
        logic seen = 1'b0;
        @(posedge hclk);
        chan <= c;
        len <= 4'(n);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        repeat (14) begin
            @(negedge hclk);
            seen = seen | flt[c];
        end
        chk({31'h0, seen}, {31'h0, e});
    endtask
    logic [15:0] dflt [16] = '{6: 16'hfaf8, 7: 16'h4046, 8: 16'h0704, 9: 16'h00ff, default: 16'h0000};
    initial begin
        logic [15:0] dw;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        go = 1'b0;
        chan = 2'b00;
        len = 4'h0;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        settle;
        for (int i = 0; i < 16; i++) rd(12'(4 * i), {16'h0, dflt[i]}, 32'hffffffff);
        chk(32'({output_select, data_edge_slow, thermal_watch_enable, input_diag_enable, output_diag_enable,
            auto_return_normal, hresp}), 32'h11a);
        $display("test defaults done");
        wr(12'h01c, 32'hffff);
        rd(12'h01c, 32'h6ff6, 32'hffffffff);
        wr(12'h01c, 32'h0);
        rd(12'h01c, 32'h4006, 32'hffffffff);
        for (int k = 0; k < 6; k++) begin
            wr(12'h01c, 32'((k % 2) << 11 | (k % 4) << 9 | (k % 4) << 7 | om[k] << 4));
            hold;
            chk(32'({data_edge_slow, output_check_level, input_check_level[1:0], output_select}),
                32'((k % 2) << 7 | (k % 4) << 5 | (k % 4) << 3 | om[k]));
        end
        $display("test control word one done");
        for (int v = 0; v < 2; v++) begin
            wr(12'h020, v ? 32'hffff : 32'h0);
            rd(12'h020, v ? 32'h0fff : 32'h0400, 32'hffffffff);
            hold;
            chk(32'({input_check_level[2], thermal_watch_enable, output_diag_enable, input_diag_enable}),
                v ? 32'hf : 32'h0);
        end
        $display("test diag word done");
        wr(12'h018, 32'h00fa);
        rd(12'h048, 32'h02eecec8, 32'h03ffffff);
        wr(12'h024, 32'h0a14);
        rd(12'h04c, 32'h003c02cb, 32'h03ff03ff);
        rd(12'h050, 32'h0, 32'hffffffff);
        $display("test decode done");
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 4; k++) begin
                dw = (c == 0) ? 16'(4 | k) : (c == 1) ? 16'(32 | k << 3) : 16'(256 | k << 6);
                wr(12'h020, {16'h0, dw});
                hold;
                streak(2'(c), lim[k], 1'b0);
                streak(2'(c), lim[k] + 1, 1'b1);
            end
        end
        wr(12'h020, 32'h0);
        hold;
        for (int c = 0; c < 3; c++) streak(2'(c), 9, 1'b0);
        $display("test faults done");
        wr(12'h01c, 32'h6046);
        cmd(32'h2);
        cmd(32'h1);
        rd(12'h044, 32'h8, 32'h8);
        wr(12'h008, 32'hffff1234);
        cmd(32'h2);
        wr(12'h008, 32'h0);
        cmd(32'h5);
        rd(12'h008, 32'h1234, 32'hffffffff);
        wr(12'h008, 32'h5678);
        cmd(32'h6);
        rd(12'h044, 32'h10, 32'h10);
        cmd(32'h5);
        rd(12'h008, 32'h1234, 32'hffffffff);
        chk({31'h0, auto_return_normal}, 32'h0);
        $display("test lock done");
        finish_test;
    end
endmodule // test_angle_sensor_config_words
